//--- hdl/scs_pkg.sv
package scs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_REF = 8'h04;
  localparam logic [7:0] OFS_BKTIME = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_EST = 8'h10;
  localparam logic [7:0] OFS_ROT = 8'h14;
  localparam logic [7:0] OFS_ANGLE = 8'h18;

  // ----------------------------------------------------------------
  // Field positions in the control and reference words
  // ----------------------------------------------------------------
  localparam int CTRL_MODE = 0;
  localparam int CTRL_INDIV = 3;
  localparam int CTRL_FEN = 4;
  localparam int CTRL_FSEL = 5;
  localparam int CTRL_REFSIDE = 8;
  localparam int CTRL_USE = 9;
  localparam int CTRL_ONSTART = 12;
  localparam int CTRL_SSA = 15;
  localparam int CTRL_SSB = 16;
  localparam int CTRL_ACLOSE = 17;
  localparam int CTRL_OBJ = 18;
  localparam int CTRL_RESTR = 21;
  localparam int REF_S1 = 0;
  localparam int REF_S2 = 4;
  localparam int REF_S3 = 8;

  // ----------------------------------------------------------------
  // Modes and limits
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TESTBLK, MODE_OFF} scs_mode_e;
  localparam logic [2:0] FORCE_NORMAL = 3'h0;
  localparam logic [2:0] FORCE_MAX = 3'h6;
  localparam logic [2:0] REF1_MAX_FULL = 3'h6;
  localparam logic [2:0] REF1_MAX_RESTR = 3'h3;
  localparam logic [1:0] REF2_MAX = 2'h3;
  localparam logic [2:0] OBJ_MAX = 3'h4;
  localparam logic [18:0] BK_MAX = 19'h57e40;
  localparam logic [18:0] BK_RESET = 19'h0000a;
  localparam logic [16:0] TIME_MAX = 17'h11940;
  localparam logic signed [19:0] ANG_MAX = 20'sh57e40;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- hdl/scs_supervisor.sv
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module scs_supervisor #(
  parameter int PROG_CYCLES = scs_pkg::PROG_CYCLES
) (
  input wire logic mclk_i, // 40 MHz clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic blocking_i, // Blocking matrix input pin
  input wire logic [2:0] stage_start_input_i, // Stage start pins
  input wire logic [2:0] mag_ok_i, // Magnitude within limit
  input wire logic [2:0] freq_ok_i, // Frequency within limit
  input wire logic [2:0] ang_ok_i, // Angle within limit
  input wire logic [16:0] est_close_i, // Time to synchronism, 5 ms units
  input wire logic [16:0] rot_time_i, // Rotation time, 5 ms units
  input wire logic signed [19:0] angle_i, // Angle, 0.001 deg units
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [2:0] match_confirmed_o, // Per-stage match confirmed
  output logic [2:0] stage_blocked_o, // Per-stage blocked
  output logic [4:0] close_cmd_o // One-clock close pulse per object
);

  typedef struct packed {
    logic awr;
    logic wr;
    logic bv;
    logic [1:0] bresp;
    logic arr;
    logic rv;
    logic [1:0] rresp;
    logic [31:0] rdata;
    scs_pkg::scs_mode_e mode;
    logic indiv;
    logic fen;
    logic [2:0] fsel;
    logic refside;
    logic [2:0] use_stage;
    logic [2:0] onstart;
    logic ssa;
    logic ssb;
    logic aclose;
    logic [2:0] obj;
    logic restr;
    logic [2:0] ref1;
    logic [1:0] ref2;
    logic ref3;
    logic [18:0] bk;
    logic [2:0] blk_s;
    logic blk_f;
    logic [2:0][2:0] st_s;
    logic [2:0] st_f;
    logic [19:0] cnt;
    logic blk_smp;
    logic [2:0] conf;
    logic [2:0] blkd;
    logic [4:0] close;
    logic done;
    logic [16:0] est;
    logic [16:0] rot;
    logic signed [19:0] ang;
  } scs_state_s;

  scs_state_s q;
  scs_state_s d;
  logic tick_w;
  logic blk_eff_w;
  logic [2:0] avail_w;
  logic [2:0] run_w;
  logic [2:0] cond_w;
  logic [31:0] ctrl_w;
  logic [31:0] ref_w;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  localparam int CTRL_MODE_HI = scs_pkg::CTRL_MODE + 2;

  // Readback views of the setting words
  always_comb begin
    ctrl_w = '0;
    ctrl_w[CTRL_MODE_HI:scs_pkg::CTRL_MODE] = q.mode;
    ctrl_w[scs_pkg::CTRL_INDIV] = q.indiv;
    ctrl_w[scs_pkg::CTRL_FEN] = q.fen;
    ctrl_w[scs_pkg::CTRL_FSEL +: 3] = q.fsel;
    ctrl_w[scs_pkg::CTRL_REFSIDE] = q.refside;
    ctrl_w[scs_pkg::CTRL_USE +: 3] = q.use_stage;
    ctrl_w[scs_pkg::CTRL_ONSTART +: 3] = q.onstart;
    ctrl_w[scs_pkg::CTRL_SSA] = q.ssa;
    ctrl_w[scs_pkg::CTRL_SSB] = q.ssb;
    ctrl_w[scs_pkg::CTRL_ACLOSE] = q.aclose;
    ctrl_w[scs_pkg::CTRL_OBJ +: 3] = q.obj;
    ctrl_w[scs_pkg::CTRL_RESTR] = q.restr;
    ref_w = '0;
    ref_w[scs_pkg::REF_S1 +: 3] = q.ref1;
    ref_w[scs_pkg::REF_S2 +: 2] = q.ref2;
    ref_w[scs_pkg::REF_S3] = q.ref3;
  end

  // ----------------------------------------------------------------
  // Stage qualification
  // ----------------------------------------------------------------
  always_comb begin
    tick_w = (q.cnt == 20'(PROG_CYCLES - 1));
    blk_eff_w = q.blk_f || q.mode == scs_pkg::MODE_BLOCKED || q.mode == scs_pkg::MODE_TESTBLK;
    avail_w[0] = (q.ssa || q.ssb) && q.ref1 != 3'h0;
    avail_w[1] = q.ssa && q.ssb && q.ref2 != 2'h0;
    avail_w[2] = q.ssa && q.ssb && q.ref3;
    for (int s = 0; s < 3; s++) begin
      run_w[s] = q.use_stage[s] && avail_w[s] && (!q.onstart[s] || q.st_f[s])
        && q.mode != scs_pkg::MODE_OFF;
      cond_w[s] = run_w[s] && mag_ok_i[s] && freq_ok_i[s] && ang_ok_i[s];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] nv;
    logic [2:0] fidx;
    nv = '0;
    fidx = '0;
    d = q;
    d.close = '0;
    // Pin synchronisers, change taken when stages two and three agree
    d.blk_s = {q.blk_s[1:0], blocking_i};
    if (q.blk_s[1] == q.blk_s[2]) begin
      d.blk_f = q.blk_s[2];
    end
    for (int s = 0; s < 3; s++) begin
      d.st_s[s] = {q.st_s[s][1:0], stage_start_input_i[s]};
      if (q.st_s[s][1] == q.st_s[s][2]) begin
        d.st_f[s] = q.st_s[s][2];
      end
    end
    // Evaluation cycle
    d.cnt = tick_w ? 20'h00000 : q.cnt + 20'h00001;
    if (tick_w) begin
      d.blk_smp = blk_eff_w;
      for (int s = 0; s < 3; s++) begin
        d.conf[s] = cond_w[s] && !blk_eff_w;
        d.blkd[s] = cond_w[s] && blk_eff_w;
      end
      if (q.fen && q.fsel != scs_pkg::FORCE_NORMAL) begin
        fidx = q.fsel - 3'h1;
        d.conf[fidx[2:1]] = fidx[0];
        d.blkd[fidx[2:1]] = !fidx[0];
      end
      d.est = (est_close_i > scs_pkg::TIME_MAX) ? scs_pkg::TIME_MAX : est_close_i;
      d.rot = (rot_time_i > scs_pkg::TIME_MAX) ? scs_pkg::TIME_MAX : rot_time_i;
      d.ang = (angle_i > scs_pkg::ANG_MAX) ? scs_pkg::ANG_MAX
        : (angle_i < -scs_pkg::ANG_MAX) ? -scs_pkg::ANG_MAX : angle_i;
      // Automatic close, stage one only, once per confirmed episode
      if (!d.conf[0]) begin
        d.done = 1'b0;
      end else if (q.aclose && !q.done && q.mode == scs_pkg::MODE_ON
                   && {2'h0, q.est} <= q.bk) begin
        d.close[q.obj] = 1'b1;
        d.done = 1'b1;
      end
    end
    // Write channel: both halves offered, accept together
    d.awr = 1'b0;
    d.wr = 1'b0;
    if (!q.awr && !q.bv && s_axi_awvalid && s_axi_wvalid) begin
      d.awr = 1'b1;
      d.wr = 1'b1;
    end
    if (q.bv && s_axi_bready) begin
      d.bv = 1'b0;
    end
    if (q.awr && s_axi_awvalid && s_axi_wvalid) begin
      d.bv = 1'b1;
      d.bresp = scs_pkg::RESP_OKAY;
      unique case (s_axi_awaddr)
        scs_pkg::OFS_CTRL: begin
          nv = merge(ctrl_w, s_axi_wdata, s_axi_wstrb);
          if (q.indiv && nv[CTRL_MODE_HI:scs_pkg::CTRL_MODE] <= 3'(scs_pkg::MODE_OFF)) begin
            d.mode = scs_pkg::scs_mode_e'(nv[CTRL_MODE_HI:scs_pkg::CTRL_MODE]);
          end
          d.indiv = nv[scs_pkg::CTRL_INDIV];
          d.fen = nv[scs_pkg::CTRL_FEN];
          if (nv[scs_pkg::CTRL_FSEL +: 3] <= scs_pkg::FORCE_MAX) begin
            d.fsel = nv[scs_pkg::CTRL_FEN] ? nv[scs_pkg::CTRL_FSEL +: 3] : scs_pkg::FORCE_NORMAL;
          end
          d.refside = nv[scs_pkg::CTRL_REFSIDE];
          d.use_stage = nv[scs_pkg::CTRL_USE +: 3];
          d.onstart = nv[scs_pkg::CTRL_ONSTART +: 3];
          d.ssa = nv[scs_pkg::CTRL_SSA];
          d.ssb = nv[scs_pkg::CTRL_SSB];
          d.aclose = nv[scs_pkg::CTRL_ACLOSE];
          if (nv[scs_pkg::CTRL_OBJ +: 3] <= scs_pkg::OBJ_MAX) begin
            d.obj = nv[scs_pkg::CTRL_OBJ +: 3];
          end
          d.restr = nv[scs_pkg::CTRL_RESTR];
        end
        scs_pkg::OFS_REF: begin
          nv = merge(ref_w, s_axi_wdata, s_axi_wstrb);
          if (nv[scs_pkg::REF_S1 +: 3] <= (q.restr ? scs_pkg::REF1_MAX_RESTR : scs_pkg::REF1_MAX_FULL)) begin
            d.ref1 = nv[scs_pkg::REF_S1 +: 3];
          end
          d.ref2 = nv[scs_pkg::REF_S2 +: 2];
          d.ref3 = nv[scs_pkg::REF_S3];
        end
        scs_pkg::OFS_BKTIME: begin
          nv = merge({13'h0000, q.bk}, s_axi_wdata, s_axi_wstrb);
          if (nv[31:19] == 13'h0000 && nv[18:0] <= scs_pkg::BK_MAX) begin
            d.bk = nv[18:0];
          end
        end
        scs_pkg::OFS_STATUS, scs_pkg::OFS_EST, scs_pkg::OFS_ROT, scs_pkg::OFS_ANGLE: begin
          d.bresp = scs_pkg::RESP_OKAY;
        end
        default: begin
          d.bresp = scs_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Read channel
    d.arr = 1'b0;
    if (!q.arr && !q.rv && s_axi_arvalid) begin
      d.arr = 1'b1;
    end
    if (q.rv && s_axi_rready) begin
      d.rv = 1'b0;
    end
    if (q.arr && s_axi_arvalid) begin
      d.rv = 1'b1;
      d.rresp = scs_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        scs_pkg::OFS_CTRL: d.rdata = ctrl_w;
        scs_pkg::OFS_REF: d.rdata = ref_w;
        scs_pkg::OFS_BKTIME: d.rdata = {13'h0000, q.bk};
        scs_pkg::OFS_STATUS: d.rdata = {21'h00000, q.done, q.blk_smp, q.blkd, q.conf, run_w};
        scs_pkg::OFS_EST: d.rdata = {15'h0000, q.est};
        scs_pkg::OFS_ROT: d.rdata = {15'h0000, q.rot};
        scs_pkg::OFS_ANGLE: d.rdata = {{12{q.ang[19]}}, q.ang};
        default: begin
          d.rdata = '0;
          d.rresp = scs_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.mode <= scs_pkg::MODE_ON;
      q.bk <= scs_pkg::BK_RESET;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = q.awr;
  assign s_axi_wready = q.wr;
  assign s_axi_bvalid = q.bv;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arr;
  assign s_axi_rvalid = q.rv;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign match_confirmed_o = q.conf;
  assign stage_blocked_o = q.blkd;
  assign close_cmd_o = q.close;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_eval;
    ce_i && tick_w && !(q.fen && q.fsel != scs_pkg::FORCE_NORMAL);
  endsequence

  sequence s_fire;
    ce_i && tick_w && q.aclose && q.mode == scs_pkg::MODE_ON && !q.done && {2'h0, q.est} <= q.bk;
  endsequence

  property p_blk_sample;
    @(posedge mclk_i) disable iff (!resetn_i) (ce_i && tick_w) |=> q.blk_smp == $past(blk_eff_w);
  endproperty
  a_blk_sample: assert property (p_blk_sample) else $error("blocking not sampled at cycle start");

  property p_confirm;
    @(posedge mclk_i) disable iff (!resetn_i) (s_eval and cond_w[0] && !blk_eff_w) |=> match_confirmed_o[0] && !stage_blocked_o[0];
  endproperty
  a_confirm: assert property (p_confirm) else $error("match not confirmed");

  property p_blocked;
    @(posedge mclk_i) disable iff (!resetn_i) (s_eval and cond_w[0] && blk_eff_w) |=> stage_blocked_o[0] && !match_confirmed_o[0];
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked not raised");

  property p_drop;
    @(posedge mclk_i) disable iff (!resetn_i) (s_eval and match_confirmed_o[0] && blk_eff_w) |=> !match_confirmed_o[0];
  endproperty
  a_drop: assert property (p_drop) else $error("confirm kept under blocking");

  property p_no_channel;
    @(posedge mclk_i) disable iff (!resetn_i) (s_eval and !q.ssa && !q.ssb) |=> match_confirmed_o == 3'h0;
  endproperty
  a_no_channel: assert property (p_no_channel) else $error("stage active without channel");

  property p_mode_lock;
    @(posedge mclk_i) disable iff (!resetn_i) (!q.indiv && ce_i) |=> q.mode == $past(q.mode);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("mode changed while locked");

  property p_force;
    @(posedge mclk_i) disable iff (!resetn_i) (ce_i && tick_w && q.fen && q.fsel == 3'h4) |=> match_confirmed_o[1] && !stage_blocked_o[1];
  endproperty
  a_force: assert property (p_force) else $error("forced ok not applied");

  property p_disabled;
    @(posedge mclk_i) disable iff (!resetn_i) (s_eval and !q.use_stage[2]) |=> !match_confirmed_o[2] && !stage_blocked_o[2];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled stage gave result");

  property p_start;
    @(posedge mclk_i) disable iff (!resetn_i) (s_eval and q.onstart[0] && !q.st_f[0]) |=> !match_confirmed_o[0];
  endproperty
  a_start: assert property (p_start) else $error("checked without start");

  property p_close;
    @(posedge mclk_i) disable iff (!resetn_i) (s_fire and d.conf[0]) |=> close_cmd_o[$past(q.obj)] && $onehot(close_cmd_o) ##1 (close_cmd_o == 5'h00 || !$past(ce_i));
  endproperty
  a_close: assert property (p_close) else $error("close pulse wrong");

  property p_close_cause;
    @(posedge mclk_i) disable iff (!resetn_i) (close_cmd_o != 5'h00) |-> $past(q.aclose) && {2'h0, $past(q.est)} <= $past(q.bk);
  endproperty
  a_close_cause: assert property (p_close_cause) else $error("close issued early");

endmodule

//--- sim/scs_far_end.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far side: blocking matrix, start pins, breaker objects
// ----------------------------------------------------------------
module scs_far_end (
  input wire logic mclk_i, // Clock
  input wire logic ce_i, // Clock enable
  input wire logic blk_req_i, // Bench asks for blocking
  input wire logic [2:0] start_req_i, // Bench asks for start pins
  input wire logic [4:0] close_cmd_i, // Close pulses from the block
  output logic blocking_o, // Blocking level
  output logic [2:0] stage_start_input_o, // Start levels
  output logic [4:0][7:0] close_cnt_o // Pulses seen per object
);
  initial begin
    blocking_o = 1'b0;
    stage_start_input_o = 3'h0;
    close_cnt_o = '0;
  end
  // Levels change just after an edge and are held
  always @(posedge mclk_i) begin
    blocking_o <= blk_req_i;
    stage_start_input_o <= start_req_i;
  end
  // Breaker objects count close pulses
  always @(posedge mclk_i) begin
    for (int i = 0; i < 5; i++) begin
      if (ce_i && close_cmd_i[i]) begin
        close_cnt_o[i] <= close_cnt_o[i] + 8'h01;
      end
    end
  end
endmodule

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int PC = 16;
  logic mclk_i, resetn_i, ce_i, blk_req, blocking_w;
  logic [2:0] start_req, start_w, mag_ok, freq_ok, ang_ok, conf, blkd;
  logic [16:0] est, rot;
  logic signed [19:0] angle;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r;
  logic [4:0] close_w;
  logic [4:0][7:0] cnt;
  int miscompares, num_checks, k;

  // ----------------------------------------------------------------
  // Block and far side
  // ----------------------------------------------------------------
  scs_supervisor #(.PROG_CYCLES(PC)) dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i), .blocking_i(blocking_w),
    .stage_start_input_i(start_w), .mag_ok_i(mag_ok), .freq_ok_i(freq_ok), .ang_ok_i(ang_ok),
    .est_close_i(est), .rot_time_i(rot), .angle_i(angle),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .match_confirmed_o(conf), .stage_blocked_o(blkd), .close_cmd_o(close_w));
  scs_far_end far (.mclk_i(mclk_i), .ce_i(ce_i), .blk_req_i(blk_req), .start_req_i(start_req),
    .close_cmd_i(close_w), .blocking_o(blocking_w), .stage_start_input_o(start_w), .close_cnt_o(cnt));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge mclk_i);
      n++;
    end while (awready !== 1'b1 && n < 40);
    @(posedge mclk_i);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1 && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 40) begin
      miscompares++;
      end_sim();
    end
    chk(32'(bresp), 32'(scs_pkg::RESP_OKAY));
    @(posedge mclk_i);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge mclk_i);
      n++;
    end while (arready !== 1'b1 && n < 40);
    @(posedge mclk_i);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 40) begin
      miscompares++;
      end_sim();
    end
    v = rdata;
    rs = rresp;
    @(posedge mclk_i);
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk(v, exp);
    chk(32'(rs), 32'(scs_pkg::RESP_OKAY));
  endtask

  // Let the pin syncs and a few evaluation ticks pass
  task automatic ticks(input int n);
    repeat (n * PC + 6) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  task automatic outs(input logic [2:0] c, input logic [2:0] b);
    chk(32'(conf), 32'(c));
    chk(32'(blkd), 32'(b));
  endtask

  task automatic cond(input logic [2:0] v);
    @(posedge mclk_i);
    mag_ok <= v;
    freq_ok <= v;
    ang_ok <= v;
  endtask

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  initial begin
    resetn_i = 1'b0;
    ce_i = 1'b1;
    {blk_req, start_req, mag_ok, freq_ok, ang_ok, est, rot, angle} = '0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    miscompares = 0;
    num_checks = 0;
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rd_chk(scs_pkg::OFS_CTRL, 32'h00000000);
    rd_chk(scs_pkg::OFS_REF, 32'h00000000);
    rd_chk(scs_pkg::OFS_BKTIME, 32'h0000000a);
    rd(8'h1c, d, r);
    chk(d, 32'h00000000);
    chk(32'(r), 32'(scs_pkg::RESP_SLVERR));
    // Stage one without a check channel stays idle
    cond(3'h7);
    est <= 17'h00005;
    rot <= 17'h13880;
    angle <= 20'h9e580;
    wr(scs_pkg::OFS_REF, 32'h00000001);
    wr(scs_pkg::OFS_CTRL, 32'h00000200);
    ticks(3);
    outs(3'h0, 3'h0);
    // Channel A, auto close to object 2
    wr(scs_pkg::OFS_CTRL, 32'h000a8200);
    ticks(3);
    outs(3'h1, 3'h0);
    chk(32'(cnt[2]), 32'h00000001);
    chk(32'(cnt[0] | cnt[1] | cnt[3] | cnt[4]), 32'h00000000);
    rd_chk(scs_pkg::OFS_EST, 32'h00000005);
    rd_chk(scs_pkg::OFS_ROT, 32'h00011940);
    rd_chk(scs_pkg::OFS_ANGLE, 32'hfffa81c0);
    // Blocking after confirmation
    @(posedge mclk_i);
    blk_req <= 1'b1;
    ticks(3);
    outs(3'h0, 3'h1);
    rd(scs_pkg::OFS_STATUS, d, r);
    chk(32'(d[9]), 32'h00000001);
    @(posedge mclk_i);
    blk_req <= 1'b0;
    ang_ok <= 3'h6;
    ticks(3);
    outs(3'h0, 3'h0);
    cond(3'h7);
    ticks(3);
    outs(3'h1, 3'h0);
    wr(scs_pkg::OFS_CTRL, 32'h00008000);
    ticks(3);
    outs(3'h0, 3'h0);
    // Start on demand, line side measured
    wr(scs_pkg::OFS_CTRL, 32'h00009300);
    rd_chk(scs_pkg::OFS_CTRL, 32'h00009300);
    ticks(3);
    outs(3'h0, 3'h0);
    @(posedge mclk_i);
    start_req <= 3'h1;
    ticks(3);
    outs(3'h1, 3'h0);
    // Mode locked until individual setting allowed
    wr(scs_pkg::OFS_CTRL, 32'h0000820c);
    rd_chk(scs_pkg::OFS_CTRL, 32'h00008208);
    wr(scs_pkg::OFS_CTRL, 32'h0000820c);
    rd_chk(scs_pkg::OFS_CTRL, 32'h0000820c);
    ticks(3);
    outs(3'h0, 3'h0);
    // Blocked, test-blocked and test modes
    wr(scs_pkg::OFS_CTRL, 32'h00008209);
    ticks(3);
    outs(3'h0, 3'h1);
    wr(scs_pkg::OFS_CTRL, 32'h0000820b);
    ticks(3);
    outs(3'h0, 3'h1);
    wr(scs_pkg::OFS_CTRL, 32'h0002820a);
    ticks(3);
    outs(3'h1, 3'h0);
    chk(32'(cnt[0]), 32'h00000000);
    // Every forced status with conditions absent
    cond(3'h0);
    wr(scs_pkg::OFS_REF, 32'h00000111);
    for (k = 1; k <= 6; k++) begin
      wr(scs_pkg::OFS_CTRL, 32'h00018e18 | (32'(k) << 5));
      ticks(3);
      outs(k[0] ? 3'h0 : 3'h1 << ((k - 1) / 2), k[0] ? 3'h1 << ((k - 1) / 2) : 3'h0);
    end
    wr(scs_pkg::OFS_CTRL, 32'h00018e18);
    ticks(3);
    outs(3'h0, 3'h0);
    // Restricted reference choices
    wr(scs_pkg::OFS_CTRL, 32'h00218e18);
    wr(scs_pkg::OFS_REF, 32'h00000115);
    rd_chk(scs_pkg::OFS_REF, 32'h00000111);
    wr(scs_pkg::OFS_REF, 32'h00000113);
    rd_chk(scs_pkg::OFS_REF, 32'h00000113);
    // Stage three follows its comparison selection
    wr(scs_pkg::OFS_CTRL, 32'h00018e08);
    wr(scs_pkg::OFS_REF, 32'h00000013);
    cond(3'h7);
    ticks(3);
    outs(3'h3, 3'h0);
    wr(scs_pkg::OFS_REF, 32'h00000113);
    ticks(3);
    outs(3'h7, 3'h0);
    // Clock enable low freezes the evaluation
    @(posedge mclk_i);
    ce_i <= 1'b0;
    cond(3'h0);
    ticks(3);
    outs(3'h7, 3'h0);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    ticks(3);
    outs(3'h0, 3'h0);
    // Breaker delay limit
    wr(scs_pkg::OFS_BKTIME, 32'h00057e41);
    rd_chk(scs_pkg::OFS_BKTIME, 32'h0000000a);
    wr(scs_pkg::OFS_BKTIME, 32'h00057e40);
    rd_chk(scs_pkg::OFS_BKTIME, 32'h00057e40);
    end_sim();
  end
endmodule
